/* File: charger_smbus_cfg.svh */
`ifndef CHARGER_SMBUS_CFG_SVH
`define CHARGER_SMBUS_CFG_SVH

// bus address and command codes
`define SLAVE_ADDR        7'h09
`define CMD_STATUS        8'h13
`define CMD_SRC_LIMIT     8'h3f
`define CMD_DEVICE_ID     8'hfe
`define CMD_MAKER_ID      8'hff

// source current limit, in mA per count
`define SRC_LIMIT_POR     16'h0100
`define SRC_LIMIT_MIN     16'h0100
`define SRC_LIMIT_MAX     16'h2afc
`define LIMIT_DROP_BITS   7
`define LIMIT_CODE_BITS   6

// status word field positions
`define STAT_ADAPTER_BIT  15
`define STAT_BATTERY_BIT  14
`define STAT_PFAIL_BIT    13

// controller register offsets and fields
`define HREG_CTRL         8'h00
`define HREG_COMMAND      8'h04
`define HREG_WDATA        8'h08
`define HREG_RDATA        8'h0c
`define HREG_STATUS       8'h10
`define CTRL_GO_BIT       0
`define CTRL_READ_BIT     1
`define HSTAT_BUSY_BIT    0
`define HSTAT_NACK_BIT    1

// link timing
`define CLK_PERIOD_NS     5
`define SCL_PERIOD_NS     80
`define SCL_QUARTER_CYC   ((`SCL_PERIOD_NS / `CLK_PERIOD_NS) / 4)

`endif

/* File: charger_smbus_pkg.sv */
package charger_smbus_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK,
    ST_IGNORE
  } dev_state_e;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_START,
    OP_BYTE,
    OP_RBYTE,
    OP_STOP
  } host_op_e;

endpackage : charger_smbus_pkg

/* File: smbus_if.sv */
`timescale 1ns/1ps
interface smbus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  wire  scl;
  wire  sda;

  // open drain with pull-up: any enabled driver holding low wins
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe,
                input scl, input sda);
  modport device (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface : smbus_if

/* File: charger_smbus_slave.sv */
// Function
// - drop seven lsbs, next six form code; code saturates at 0x3f from 8192mA
// - limit word counts one milliamp each
// - requests above top clamp to 11.004A
// - requests at/below bottom forced to 256mA
// - limit resets to 256mA minimum
// - adapter above 7.5V permits charge, bit15
// - power fail opens source switch, bit13
// - thermistor below 91% means battery, bit14
// - battery undervoltage caps charge at 128mA
// - logic undervoltage ignores bus, stops charge
// - undervoltage recovery restores power-on state
// - device is slave only, never initiates
// - answer only address 0b0001001
// - two read-only identity words by read-word
// - master opens with start condition
// - master closes with stop condition
// - sda changes only while scl low
// - bytes msb first, sampled on rising scl
// - nine clocks per byte, receiver acknowledges
// - only read-word and write-word transfers
// - status word returned by command 0x13
`timescale 1ns/1ps
`include "charger_smbus_cfg.svh"
module charger_smbus_slave
  import charger_smbus_pkg::*;
#(
  parameter logic [6:0]  SLAVE_ADDR  = `SLAVE_ADDR,
  parameter logic [15:0] DEVICE_ID   = 16'h0a5a,  // arbitrary value
  parameter logic [15:0] MAKER_ID    = 16'h005a   // arbitrary value
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  smbus_if.device          bus,
  input  wire logic        adapter_above_7v5,
  input  wire logic        adapter_below_battery_voltage_input_margin,
  input  wire logic        thermistor_below_91pct,
  input  wire logic        battery_voltage_input_below_2v5,
  input  wire logic        battery_voltage_input_above_2v7,
  input  wire logic        vdd_below_2v5,
  output logic             adapter_present_flag,
  output logic             source_switch_drive,
  output logic             charge_enable,
  output logic             charge_limit_128ma,
  output logic [15:0]      src_limit_ma,
  output logic [5:0]       limit_code
);

  if (SLAVE_ADDR == 7'h00) begin : g_chk
    $error("general call address cannot be the slave address");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers; stage 3 only delays stage 2 for edge finding
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [1:0] bus_d;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 8'hc0;
      sync2 <= 8'hc0;
      bus_d <= 2'h3;
    end else begin
      sync1 <= {bus.scl, bus.sda, vdd_below_2v5, battery_voltage_input_above_2v7, battery_voltage_input_below_2v5,
                thermistor_below_91pct, adapter_below_battery_voltage_input_margin, adapter_above_7v5};
      sync2 <= sync1;
      bus_d <= sync2[7:6];
    end
  end

  wire scl_s      = sync2[7];
  wire sda_s      = sync2[6];
  wire vdd_uv     = sync2[5];
  wire battery_voltage_input_hi    = sync2[4];
  wire battery_voltage_input_lo    = sync2[3];
  wire battery_voltage_input_in    = sync2[2];
  wire pfail      = sync2[1];
  wire adapter_ok = sync2[0];

  wire scl_rise   = scl_s & ~bus_d[1];
  wire scl_fall   = ~scl_s & bus_d[1];
  wire start_seen = scl_s & bus_d[1] & bus_d[0] & ~sda_s;
  wire stop_seen  = scl_s & bus_d[1] & ~bus_d[0] & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic readable(input logic [7:0] cmd);
    readable = (cmd == `CMD_STATUS) || (cmd == `CMD_DEVICE_ID) || (cmd == `CMD_MAKER_ID);
  endfunction : readable

  function automatic logic [15:0] clamp_limit(input logic [15:0] req);
    if (req > `SRC_LIMIT_MAX)
      clamp_limit = `SRC_LIMIT_MAX;
    else if (req <= `SRC_LIMIT_MIN)
      clamp_limit = `SRC_LIMIT_MIN;
    else
      clamp_limit = req;
  endfunction : clamp_limit

  dev_state_e  state;
  logic [3:0]  bitcnt;
  logic [2:0]  byte_idx;
  logic [7:0]  rx_sh;
  logic [7:0]  tx_sh;
  logic [7:0]  cmd;
  logic        cmd_valid;
  logic [7:0]  data_lo;
  logic        tx_high;
  logic        master_ack;
  logic        sda_low;
  logic        battery_voltage_input_uv;
  logic [15:0] src_limit;

  wire [15:0] status_word = {adapter_ok, battery_voltage_input_in, pfail, 13'h0000};
  wire [15:0] read_word   = (cmd == `CMD_STATUS)    ? status_word :
                            (cmd == `CMD_DEVICE_ID) ? DEVICE_ID   : MAKER_ID;

  // byte decision at the falling edge ending the eighth bit
  wire addr_hit   = (rx_sh[7:1] == SLAVE_ADDR);
  wire is_read    = rx_sh[0];
  wire byte_done  = (state == ST_RX) && scl_fall && (bitcnt == 4'd8);
  wire take_byte  = (byte_idx == 3'd0) ? (addr_hit && (!is_read || (cmd_valid && readable(cmd)))) :
                    (byte_idx <= 3'd3);
  wire go_tx      = (byte_idx == 3'd0) && is_read;

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine; logic undervoltage holds everything at power-on values
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_IDLE;
      bitcnt     <= 4'h0;
      byte_idx   <= 3'h0;
      rx_sh      <= 8'h00;
      tx_sh      <= 8'h00;
      cmd        <= 8'h00;
      cmd_valid  <= 1'b0;
      data_lo    <= 8'h00;
      tx_high    <= 1'b0;
      master_ack <= 1'b0;
      sda_low    <= 1'b0;
      src_limit  <= `SRC_LIMIT_POR;
    end else if (vdd_uv) begin
      state      <= ST_IDLE;
      bitcnt     <= 4'h0;
      byte_idx   <= 3'h0;
      rx_sh      <= 8'h00;
      tx_sh      <= 8'h00;
      cmd        <= 8'h00;
      cmd_valid  <= 1'b0;
      data_lo    <= 8'h00;
      tx_high    <= 1'b0;
      master_ack <= 1'b0;
      sda_low    <= 1'b0;
      src_limit  <= `SRC_LIMIT_POR;
    end else if (stop_seen) begin
      state      <= ST_IDLE;
      sda_low    <= 1'b0;
      cmd_valid  <= 1'b0;
    end else if (start_seen) begin
      // repeated start keeps the command for the read half
      state      <= ST_RX;
      bitcnt     <= 4'h0;
      byte_idx   <= 3'h0;
      sda_low    <= 1'b0;
    end else begin
      case (state)
        ST_RX: begin
          if (scl_rise) begin
            rx_sh  <= {rx_sh[6:0], sda_s};
            bitcnt <= bitcnt + 4'd1;
          end else if (byte_done) begin
            if (take_byte) begin
              sda_low <= 1'b1;
              state   <= ST_ACK;
              if (byte_idx == 3'd1) begin
                cmd       <= rx_sh;
                cmd_valid <= 1'b1;
              end
              if (byte_idx == 3'd2)
                data_lo <= rx_sh;
              if (byte_idx == 3'd3 && cmd == `CMD_SRC_LIMIT)
                src_limit <= clamp_limit({rx_sh, data_lo});
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bitcnt   <= 4'h0;
            byte_idx <= byte_idx + 3'd1;
            if (go_tx) begin
              tx_sh   <= read_word[7:0];
              tx_high <= 1'b0;
              sda_low <= ~read_word[7];
              state   <= ST_TX;
            end else begin
              sda_low <= 1'b0;
              state   <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'd1;
          end else if (scl_fall) begin
            if (bitcnt == 4'd8) begin
              sda_low <= 1'b0;
              state   <= ST_MACK;
            end else begin
              tx_sh   <= {tx_sh[6:0], 1'b0};
              sda_low <= ~tx_sh[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_s;
          end else if (scl_fall) begin
            if (master_ack && !tx_high) begin
              tx_sh   <= read_word[15:8];
              tx_high <= 1'b1;
              sda_low <= ~read_word[15];
              bitcnt  <= 4'h0;
              state   <= ST_TX;
            end else begin
              state   <= ST_IGNORE;
            end
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_low <= 1'b0;
        end
        default: begin
          state   <= ST_IDLE;
          sda_low <= 1'b0;
        end
      endcase
    end
  end

  // only ever pulls the data line low; clock is never driven
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_low;

  ////////////////////////////////////////////////////////////////////////////
  // operating state outputs; uv latch has hysteresis between 2.5V and 2.7V
  wire next_battery_voltage_input_uv = battery_voltage_input_lo ? 1'b1 : (battery_voltage_input_hi ? 1'b0 : battery_voltage_input_uv);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      battery_voltage_input_uv              <= 1'b0;
      adapter_present_flag <= 1'b0;
      source_switch_drive  <= 1'b0;
      charge_enable        <= 1'b0;
      charge_limit_128ma   <= 1'b0;
      src_limit_ma         <= `SRC_LIMIT_POR;
      limit_code           <= 6'h00;
    end else begin
      battery_voltage_input_uv              <= vdd_uv ? 1'b0 : next_battery_voltage_input_uv;
      adapter_present_flag <= adapter_ok;
      source_switch_drive  <= ~pfail;
      charge_enable        <= adapter_ok & ~pfail & ~vdd_uv;
      charge_limit_128ma   <= next_battery_voltage_input_uv & ~vdd_uv;
      src_limit_ma         <= src_limit;
      // the upper clamp exceeds six bits of code, so the code saturates
      limit_code           <= (|src_limit[15:13]) ? 6'h3f :
                              src_limit[`LIMIT_DROP_BITS +: `LIMIT_CODE_BITS];
    end
  end

endmodule : charger_smbus_slave

/* File: charger_smbus_master.sv */
`timescale 1ns/1ps
`include "charger_smbus_cfg.svh"
module charger_smbus_master
  import charger_smbus_pkg::*;
#(
  parameter int          SCL_QUARTER = `SCL_QUARTER_CYC,
  parameter logic [6:0]  SLAVE_ADDR  = `SLAVE_ADDR
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  smbus_if.host            bus
);

  // the slave needs a few cycles to see each clock edge
  if (SCL_QUARTER < 4) begin : g_chk
    $error("SCL_QUARTER below 4 leaves the slave no time to react");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register slave
  logic [7:0]  aw_addr;
  logic        aw_hold;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_hold;
  logic [7:0]  cmd;
  logic [15:0] wr_word;
  logic [15:0] rd_word;
  logic        busy;
  logic        nack_err;
  logic        op_read;

  wire do_write = aw_hold & w_hold & ~bvalid;
  wire wr_ctrl  = do_write && (aw_addr == `HREG_CTRL);
  wire wr_cmd   = do_write && (aw_addr == `HREG_COMMAND);
  wire wr_data  = do_write && (aw_addr == `HREG_WDATA);
  wire wr_ok    = wr_ctrl | wr_cmd | wr_data;
  wire go       = wr_ctrl && w_strb[0] && w_data[`CTRL_GO_BIT] && !busy;
  wire rd_ok    = (araddr == `HREG_CTRL) || (araddr == `HREG_COMMAND) || (araddr == `HREG_WDATA) ||
                  (araddr == `HREG_RDATA) || (araddr == `HREG_STATUS);
  wire [31:0] rd_mux = (araddr == `HREG_COMMAND) ? {24'h000000, cmd} :
                       (araddr == `HREG_WDATA)   ? {16'h0000, wr_word} :
                       (araddr == `HREG_RDATA)   ? {16'h0000, rd_word} :
                       (araddr == `HREG_STATUS)  ? {30'h00000000, nack_err, busy} :
                       (araddr == `HREG_CTRL)    ? {30'h00000000, op_read, 1'b0} : 32'h00000000;

  assign awready = ~aw_hold & ~bvalid;
  assign wready  = ~w_hold & ~bvalid;
  assign arready = ~rvalid;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_addr <= 8'h00;
      aw_hold <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      w_hold  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      rvalid  <= 1'b0;
      rresp   <= 2'h0;
      rdata   <= 32'h00000000;
      cmd     <= 8'h00;
      wr_word <= 16'h0000;
      op_read <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_hold <= 1'b1;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_hold <= 1'b1;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? 2'h0 : 2'h2;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (wr_cmd && w_strb[0])
        cmd <= w_data[7:0];
      if (wr_data && w_strb[0])
        wr_word[7:0] <= w_data[7:0];
      if (wr_data && w_strb[1])
        wr_word[15:8] <= w_data[15:8];
      if (go)
        op_read <= w_data[`CTRL_READ_BIT];
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_mux;
        rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: each segment is one start, stop or nine-bit byte
  logic [15:0] div;
  logic [1:0]  quarter;
  logic [3:0]  bitn;
  logic [2:0]  seg;
  logic        abort;
  logic [7:0]  rx_sh;
  logic        sda_s1;
  logic        sda_s2;
  logic        scl_low;
  logic        sda_low;

  function automatic host_op_e seg_op(input logic [2:0] s, input logic rd);
    case (s)
      3'd0:    seg_op = OP_START;
      3'd1:    seg_op = OP_BYTE;
      3'd2:    seg_op = OP_BYTE;
      3'd3:    seg_op = rd ? OP_START : OP_BYTE;               // repeated start
      3'd4:    seg_op = OP_BYTE;
      3'd5:    seg_op = rd ? OP_RBYTE : OP_STOP;
      3'd6:    seg_op = OP_RBYTE;
      default: seg_op = OP_STOP;
    endcase
  endfunction : seg_op

  wire host_op_e op       = busy ? seg_op(seg, op_read) : OP_NONE;
  wire [2:0]     stop_seg = op_read ? 3'd7 : 3'd5;
  wire [7:0]     tx_byte  = (seg == 3'd1) ? {SLAVE_ADDR, 1'b0} :
                            (seg == 3'd2) ? cmd :
                            (seg == 3'd3) ? wr_word[7:0] :
                            (seg == 3'd4) ? (op_read ? {SLAVE_ADDR, 1'b1} : wr_word[15:8]) : 8'h00;
  wire           tick     = (div == 16'(SCL_QUARTER - 1));
  wire           scl_mid  = (quarter == 2'd1) || (quarter == 2'd2);
  wire           last_rx  = (seg == 3'd6);
  wire           byte_op  = (op == OP_BYTE) || (op == OP_RBYTE);
  wire           seg_end  = tick && (quarter == 2'd3) && (!byte_op || bitn == 4'd8);
  wire           next_scl = (op == OP_NONE) ? 1'b1 : (op == OP_STOP) ? (quarter != 2'd0) : scl_mid;
  wire           next_sda = (op == OP_NONE)  ? 1'b1 :
                            (op == OP_START) ? (quarter < 2'd2) :
                            (op == OP_STOP)  ? (quarter >= 2'd2) :
                            (bitn == 4'd8)   ? ((op == OP_BYTE) || last_rx) :
                            (op == OP_BYTE)  ? tx_byte[3'(4'd7 - bitn)] : 1'b1;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div      <= 16'h0000;
      quarter  <= 2'h0;
      bitn     <= 4'h0;
      seg      <= 3'h0;
      abort    <= 1'b0;
      busy     <= 1'b0;
      nack_err <= 1'b0;
      rx_sh    <= 8'h00;
      rd_word  <= 16'h0000;
      scl_low  <= 1'b0;
      sda_low  <= 1'b0;
    end else begin
      scl_low <= ~next_scl;
      sda_low <= ~next_sda;
      if (go) begin
        busy     <= 1'b1;
        nack_err <= 1'b0;
        seg      <= 3'h0;
        bitn     <= 4'h0;
        quarter  <= 2'h0;
        div      <= 16'h0000;
        abort    <= 1'b0;
      end else if (busy) begin
        div <= tick ? 16'h0000 : div + 16'h0001;
        if (tick) begin
          quarter <= quarter + 2'd1;
          if (quarter == 2'd2 && byte_op) begin
            if (bitn == 4'd8 && op == OP_BYTE && sda_s2) begin
              abort    <= 1'b1;
              nack_err <= 1'b1;
            end
            if (bitn < 4'd8 && op == OP_RBYTE)
              rx_sh <= {rx_sh[6:0], sda_s2};
          end
          if (quarter == 2'd3 && byte_op && bitn != 4'd8)
            bitn <= bitn + 4'd1;
        end
        if (seg_end) begin
          bitn  <= 4'h0;
          abort <= 1'b0;
          if (op == OP_RBYTE && seg == 3'd5)
            rd_word[7:0] <= rx_sh;
          if (op == OP_RBYTE && seg == 3'd6)
            rd_word[15:8] <= rx_sh;
          if (op == OP_STOP)
            busy <= 1'b0;
          else
            seg <= abort ? stop_seg : seg + 3'd1;
        end
      end
    end
  end

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_scl_oe = scl_low;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = sda_low;

endmodule : charger_smbus_master

/* File: charger_smbus_assertions.sv */
`timescale 1ns/1ps
module charger_smbus_assertions (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  logic [3:0] bitcnt;
  logic [7:0] shreg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // clocks since the last start or stop; saturates so long frames never wrap
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bitcnt <= 4'h0;
      shreg  <= 8'h00;
    end else if (scl && $changed(sda)) begin
      bitcnt <= 4'h0;
    end else if ($rose(scl) && bitcnt != 4'hf) begin
      bitcnt <= bitcnt + 4'h1;
      if (bitcnt < 4'h8) begin
        shreg <= {shreg[6:0], sda};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence ninth_write_clock;
    $rose(scl) ##1 (bitcnt == 4'h9 && !shreg[0]);
  endsequence

  addr_hands_off_a: assert property (scl && $past(scl) && bitcnt >= 4'h1 && bitcnt <= 4'h8 |-> !dev_sda_oe)
    else $error("device drove sda during the address byte");
  addr_write_ack_a: assert property (ninth_write_clock |-> dev_sda_oe == (shreg[7:1] == 7'h09))
    else $error("address acknowledge does not match the slave address");
  host_yields_ack_a: assert property (ninth_write_clock |-> !host_sda_oe)
    else $error("host still drives sda in the acknowledge clock");
  bit_hold_a: assert property ($rose(scl) |=> $stable(dev_sda_oe) [*7])
    else $error("device sda moved while scl high");
  dev_change_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device sda changed with scl high");
  scl_low_span_a: assert property ($fell(scl) |-> !scl [*4] ##[1:5] scl)
    else $error("scl low phase out of range");
  scl_high_span_a: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  open_drain_a: assert property ((dev_sda_oe |-> !dev_sda_o) and (host_sda_oe |-> !host_sda_o))
    else $error("sda driven high instead of released");
  start_by_host_a: assert property (scl && $past(scl) && $fell(sda) |-> host_sda_oe && !dev_sda_oe)
    else $error("start not formed by the host");
  stop_by_host_a: assert property (scl && $past(scl) && $rose(sda) |-> $past(host_sda_oe) && !dev_sda_oe)
    else $error("stop not formed by the host");
endmodule : charger_smbus_assertions

/* File: charger_smbus_slave_state_logic_tb_top.sv */
`timescale 1ns/1ps
`include "charger_smbus_cfg.svh"
module charger_smbus_slave_state_logic_tb_top;
  localparam logic [15:0] DEV_ID   = 16'h1234;  // arbitrary value
  localparam logic [15:0] MAKER_ID = 16'h0042;  // arbitrary value
  logic        clk_sys;
  logic        arst_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd_val;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [5:0]  dev_in;  // vdd, battery_voltage_input hi, battery_voltage_input lo, therm, pfail, adapter
  logic [1:0]  rsp;
  logic [15:0] v;
  logic [2:0]  f;
  logic [15:0] corner [6] = '{16'h0000, 16'h0100, 16'h0101, 16'h2afc, 16'h2afd, 16'hffff};
  wire         awready, wready, bvalid, arready, rvalid, adp, ssw, chg, lim128;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] src_ma;
  wire  [5:0]  code;
  int          errors, compares, seed, i;

  smbus_if bus ();
  charger_smbus_master i_charger_smbus_master (.clk_sys(clk_sys), .arst_n(arst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .bus(bus));
  charger_smbus_slave #(.DEVICE_ID(DEV_ID), .MAKER_ID(MAKER_ID)) i_charger_smbus_slave (.clk_sys(clk_sys),
    .arst_n(arst_n), .bus(bus), .adapter_above_7v5(dev_in[0]), .adapter_below_battery_voltage_input_margin(dev_in[1]),
    .thermistor_below_91pct(dev_in[2]), .battery_voltage_input_below_2v5(dev_in[3]), .battery_voltage_input_above_2v7(dev_in[4]),
    .vdd_below_2v5(dev_in[5]), .adapter_present_flag(adp), .source_switch_drive(ssw), .charge_enable(chg),
    .charge_limit_128ma(lim128), .src_limit_ma(src_ma), .limit_code(code));
  charger_smbus_assertions i_charger_smbus_assertions (.clk_sys(clk_sys), .arst_n(arst_n), .scl(bus.scl),
    .sda(bus.sda), .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o),
    .dev_sda_oe(bus.dev_sda_oe));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_limit(input logic [15:0] r);
    if (r > `SRC_LIMIT_MAX) return `SRC_LIMIT_MAX;
    if (r <= `SRC_LIMIT_MIN) return `SRC_LIMIT_MIN;
    return r;
  endfunction : exp_limit

  // code saturates: the top of range needs more than six bits
  function automatic logic [5:0] exp_code(input logic [15:0] l);
    return (l >= 16'h2000) ? 6'h3f : l[12:7];
  endfunction : exp_code

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task end_of_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task hang;
    errors++;
    end_of_test();
  endtask : hang

  ////////////////////////////////////////////////////////////////////////////
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    // one idle edge so the next call never re-raises a strobe in this time step
    @(posedge clk_sys);
    if (n == 100) hang();
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    int n;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_val = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
    if (n == 100) hang();
  endtask : axi_rd

  task smb(input logic rd, input logic [7:0] cmd, input logic [15:0] d);
    int n;
    axi_wr(`HREG_COMMAND, {24'h0, cmd});
    axi_wr(`HREG_WDATA, {16'h0, d});
    axi_wr(`HREG_CTRL, {30'h0, rd, 1'b1});
    for (n = 0; n < 2000; n++) begin
      axi_rd(`HREG_STATUS);
      if (rd_val[`HSTAT_BUSY_BIT] === 1'b0) break;
    end
    if (n == 2000) hang();
    if (rd) axi_rd(`HREG_RDATA);
  endtask : smb

  // inputs pass two sync flops and an output register
  task set_in(input logic [5:0] s);
    dev_in <= s;
    repeat (6) @(posedge clk_sys);
  endtask : set_in

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, dev_in} = '0;
    {errors, compares} = '0;
    seed = 86;
    arst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(src_ma, `SRC_LIMIT_POR);
    chk(code, exp_code(`SRC_LIMIT_POR));
    for (i = 0; i < 12; i++) begin
      v = (i < 6) ? corner[i] : 16'($random(seed));
      smb(1'b0, `CMD_SRC_LIMIT, v);
      chk(src_ma, exp_limit(v));
      chk(code, exp_code(exp_limit(v)));
    end
    smb(1'b0, 8'h14, 16'h0800);
    chk(src_ma, exp_limit(v));
    for (i = 0; i < 8; i++) begin
      f = 3'($random(seed));
      set_in({3'b000, f});
      smb(1'b1, `CMD_STATUS, 16'h0000);
      chk(rd_val[15:0], {f[0], f[2], f[1], 13'h0});
      chk(adp, f[0]);
      chk(ssw, !f[1]);
      chk(chg, f[0] & !f[1]);
    end
    smb(1'b1, `CMD_DEVICE_ID, 16'h0000);
    chk(rd_val[15:0], DEV_ID);
    smb(1'b1, `CMD_MAKER_ID, 16'h0000);
    chk(rd_val[15:0], MAKER_ID);
    // a read of a write-only command is refused with a nack
    smb(1'b1, 8'h14, 16'h0000);
    axi_rd(`HREG_STATUS);
    chk(rd_val[`HSTAT_NACK_BIT], 1'b1);
    axi_wr(8'h40, 32'h0);
    chk(rsp, 2'b10);
    axi_rd(8'h40);
    chk(rsp, 2'b10);
    set_in(6'h09);
    chk(lim128, 1'b1);
    set_in(6'h01);
    chk(lim128, 1'b1);
    chk(src_ma, exp_limit(v));
    set_in(6'h11);
    chk(lim128, 1'b0);
    set_in(6'h21);
    chk(chg, 1'b0);
    set_in(6'h01);
    chk(src_ma, `SRC_LIMIT_POR);
    smb(1'b0, `CMD_SRC_LIMIT, 16'h0400);
    chk(src_ma, 16'h0400);
    end_of_test();
  end
endmodule : charger_smbus_slave_state_logic_tb_top
